/* File: pimux_pkg.sv */
// constants and types for the port pad function multiplexer
package pimux_pkg;

  localparam int PAD_NUM = 10;
  localparam int CFG_W   = 6;
  localparam int SEL_W   = 2;

  // pad lanes
  localparam int PAD_PI5  = 0;
  localparam int PAD_PI6  = 1;
  localparam int PAD_PI7  = 2;
  localparam int PAD_PI8  = 3;
  localparam int PAD_PI12 = 4;
  localparam int PAD_PI13 = 5;
  localparam int PAD_PC0  = 6;
  localparam int PAD_PC1  = 7;
  localparam int PAD_PH9  = 8;
  localparam int PAD_PH10 = 9;

  // pad_config_reg fields
  localparam int FSEL_LSB = 0;
  localparam int OBE_BIT  = 2;
  localparam int IBE_BIT  = 3;
  localparam int NMI_BIT  = 4;
  localparam int MED_BIT  = 5;

  localparam logic [SEL_W-1:0] SEL_GPIO = 2'h0;
  localparam logic [SEL_W-1:0] SEL_ONE  = 2'h1;
  localparam logic [SEL_W-1:0] SEL_TWO  = 2'h2;
  localparam logic [SEL_W-1:0] SEL_THREE = 2'h3;

  localparam logic [CFG_W-1:0] CFG_RST_TRI  = 6'h00;
  localparam logic [CFG_W-1:0] CFG_RST_SCAN = 6'h0a;
  localparam logic [CFG_W-1:0] CFG_RST_TDO  = 6'h26;

  localparam logic [CFG_W-1:0] CFG_RST [PAD_NUM] = '{
    CFG_RST_TRI, CFG_RST_TRI, CFG_RST_TRI, CFG_RST_TRI, CFG_RST_TRI,
    CFG_RST_TRI, CFG_RST_SCAN, CFG_RST_TDO, CFG_RST_SCAN, CFG_RST_SCAN};

  // which selectors carry a function on each lane
  localparam logic [PAD_NUM-1:0] AVAIL_ONE   = 10'h037;
  localparam logic [PAD_NUM-1:0] AVAIL_TWO   = 10'h3c7;
  localparam logic [PAD_NUM-1:0] AVAIL_THREE = 10'h000;

  localparam int CONV_CH_PI8  = 16;
  localparam int CONV_CH_PI12 = 20;
  localparam int CONV_CH_PI13 = 21;

  typedef enum logic [2:0] {
    PT_FAST   = 3'h0,
    PT_IN_AN  = 3'h1,
    PT_BIDIR_AN = 3'h2,
    PT_MEDIUM = 3'h3,
    PT_SLOW   = 3'h4
  } pimux_pad_type_t;

  localparam pimux_pad_type_t PAD_TYPE [PAD_NUM] = '{
    PT_SLOW, PT_SLOW, PT_SLOW, PT_BIDIR_AN, PT_BIDIR_AN,
    PT_BIDIR_AN, PT_MEDIUM, PT_FAST, PT_SLOW, PT_MEDIUM};

  function automatic logic pimux_is_analog(pimux_pad_type_t t);
    return (t == PT_IN_AN) || (t == PT_BIDIR_AN);
  endfunction

endpackage

/* File: pimux_pad_slice.sv */
// one pad lane: output drive selection from the pad configuration
module pimux_pad_slice
  import pimux_pkg::*;
(
  input  wire logic [pimux_pkg::CFG_W-1:0] cfg,
  input  wire logic                        gpio_out,
  input  wire logic [3:1]                  alt_out,
  input  wire logic [3:1]                  alt_oe,
  input  wire logic [3:1]                  avail,
  output logic                             drv,
  output logic                             drv_en
);
  logic [SEL_W-1:0] sel;

  always_comb
  begin
    sel    = cfg[FSEL_LSB +: SEL_W];
    drv    = 1'b0;
    drv_en = 1'b0;
    if (cfg[NMI_BIT])
    begin
      drv    = 1'b0;
      drv_en = 1'b0;
    end
    else if (sel == SEL_GPIO)
    begin
      drv    = gpio_out;
      drv_en = cfg[OBE_BIT];
    end
    else if (avail[sel])
    begin
      drv    = alt_out[sel];
      drv_en = alt_oe[sel];
    end
  end
endmodule

/* File: pimux_top.sv */
// port pad function multiplexer with per-pad configuration registers
module pimux_top #(
  parameter logic [pimux_pkg::PAD_NUM-1:0] WAKE_MASK = 10'h000
)(
  input  wire logic                                        core_clk,
  input  wire logic                                        rst,
  input  wire logic [pimux_pkg::PAD_NUM-1:0]               cfg_wr_en,
  input  wire logic [pimux_pkg::CFG_W-1:0]                 cfg_wr_data,
  input  wire logic [pimux_pkg::PAD_NUM-1:0]               gpio_out,
  input  wire logic [3:1][pimux_pkg::PAD_NUM-1:0]          alt_out,
  input  wire logic [3:1][pimux_pkg::PAD_NUM-1:0]          alt_oe,
  input  wire logic                                        scan_data_out,
  input  wire logic                                        scan_data_out_en,
  input  wire logic [pimux_pkg::PAD_NUM-1:0]               pad_in,
  output logic      [pimux_pkg::PAD_NUM-1:0]               pad_out,
  output logic      [pimux_pkg::PAD_NUM-1:0]               pad_oe_n,
  output logic      [pimux_pkg::PAD_NUM-1:0]               pad_medium,
  output logic      [pimux_pkg::PAD_NUM*pimux_pkg::CFG_W-1:0] pad_config_state,
  output logic      [pimux_pkg::PAD_NUM-1:0]               gpio_in,
  output logic      [3:1][pimux_pkg::PAD_NUM-1:0]          alt_in,
  output logic                                             scan_data_in,
  output logic                                             scan_clk,
  output logic                                             scan_mode_sel,
  output logic      [pimux_pkg::PAD_NUM-1:0]               nmi_in,
  output logic                                             converter0_standard_input_16,
  output logic                                             converter0_standard_input_20,
  output logic                                             converter0_standard_input_21,
  output logic      [pimux_pkg::PAD_NUM-1:0]               wakeup_line,
  output logic      [pimux_pkg::PAD_NUM-1:0]               ext_irq_line
);
  import pimux_pkg::*;

  logic [CFG_W-1:0]          pad_config_reg [PAD_NUM];
  logic [3:1][PAD_NUM-1:0]   avail_vec;
  logic [3:1][PAD_NUM-1:0]   alt_out_eff;
  logic [3:1][PAD_NUM-1:0]   alt_oe_eff;
  logic [PAD_NUM-1:0]        drv;
  logic [PAD_NUM-1:0]        drv_en;
  logic [PAD_NUM-1:0]        analog_vec;
  logic [PAD_NUM-1:0]        pad_out_reg;
  logic [PAD_NUM-1:0]        pad_oe_n_reg;
  logic [PAD_NUM-1:0]        gpio_in_reg;
  logic [3:1][PAD_NUM-1:0]   alt_in_reg;
  logic [PAD_NUM-1:0]        nmi_in_reg;
  logic [PAD_NUM-1:0]        wake_reg;
  logic [2:0]                conv_reg;
  logic [2:0]                scan_in_reg;

  assign avail_vec[1] = AVAIL_ONE;
  assign avail_vec[2] = AVAIL_TWO;
  assign avail_vec[3] = AVAIL_THREE;

  // scan data out rides selector two of port C 1
  always_comb
  begin
    alt_out_eff = alt_out;
    alt_oe_eff  = alt_oe;
    alt_out_eff[2][PAD_PC1] = scan_data_out;
    alt_oe_eff[2][PAD_PC1]  = scan_data_out_en;
  end

  genvar g;
  generate
    for (g = 0; g < PAD_NUM; g++)
    begin : gen_pad
      // analog path only on analog types
      assign analog_vec[g] = pimux_is_analog(PAD_TYPE[g]);
      assign pad_config_state[g*CFG_W +: CFG_W] = pad_config_reg[g];

      always_ff @(posedge core_clk)
      begin
        if (rst)
          pad_config_reg[g] <= CFG_RST[g];
        else if (cfg_wr_en[g])
          pad_config_reg[g] <= cfg_wr_data;
      end

      pimux_pad_slice u_slice (
        .cfg      (pad_config_reg[g]),
        .gpio_out (gpio_out[g]),
        .alt_out  ({alt_out_eff[3][g], alt_out_eff[2][g], alt_out_eff[1][g]}),
        .alt_oe   ({alt_oe_eff[3][g], alt_oe_eff[2][g], alt_oe_eff[1][g]}),
        .avail    ({avail_vec[3][g], avail_vec[2][g], avail_vec[1][g]}),
        .drv      (drv[g]),
        .drv_en   (drv_en[g])
      );

      always_ff @(posedge core_clk)
      begin
        if (rst)
        begin
          pad_out_reg[g]  <= 1'b0;
          pad_oe_n_reg[g] <= 1'b1;
        end
        else
        begin
          pad_out_reg[g]  <= drv[g];
          pad_oe_n_reg[g] <= ~drv_en[g];
        end
      end

      always_ff @(posedge core_clk)
      begin
        if (rst)
        begin
          gpio_in_reg[g]   <= 1'b0;
          nmi_in_reg[g]    <= 1'b0;
          alt_in_reg[1][g] <= 1'b0;
          alt_in_reg[2][g] <= 1'b0;
          alt_in_reg[3][g] <= 1'b0;
        end
        else
        begin
          gpio_in_reg[g] <= pad_in[g] & pad_config_reg[g][IBE_BIT];
          nmi_in_reg[g]  <= pad_in[g] & pad_config_reg[g][NMI_BIT];
          alt_in_reg[1][g] <= pad_in[g] & ~pad_config_reg[g][NMI_BIT] & avail_vec[1][g]
                              & (pad_config_reg[g][FSEL_LSB +: SEL_W] == SEL_ONE);
          alt_in_reg[2][g] <= pad_in[g] & ~pad_config_reg[g][NMI_BIT] & avail_vec[2][g]
                              & (pad_config_reg[g][FSEL_LSB +: SEL_W] == SEL_TWO);
          alt_in_reg[3][g] <= pad_in[g] & ~pad_config_reg[g][NMI_BIT] & avail_vec[3][g]
                              & (pad_config_reg[g][FSEL_LSB +: SEL_W] == SEL_THREE);
        end
      end

      always_ff @(posedge core_clk)
      begin
        if (rst)
          wake_reg[g] <= 1'b0;
        else
          wake_reg[g] <= pad_in[g] & WAKE_MASK[g];
      end
    end
  endgenerate

  always_ff @(posedge core_clk)
  begin
    if (rst)
      conv_reg <= 3'h0;
    else
      conv_reg <= {pad_in[PAD_PI13] & analog_vec[PAD_PI13],
                   pad_in[PAD_PI12] & analog_vec[PAD_PI12],
                   pad_in[PAD_PI8] & analog_vec[PAD_PI8]};
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      scan_in_reg <= 3'h0;
    else
      scan_in_reg <= {alt_in_reg[2][PAD_PH10], alt_in_reg[2][PAD_PH9], alt_in_reg[2][PAD_PC0]};
  end

  always_comb
  begin
    for (int i = 0; i < PAD_NUM; i++)
      pad_medium[i] = pad_config_reg[i][MED_BIT];
  end

  assign pad_out       = pad_out_reg;
  assign pad_oe_n      = pad_oe_n_reg;
  assign gpio_in       = gpio_in_reg;
  assign alt_in        = alt_in_reg;
  assign nmi_in        = nmi_in_reg;
  assign wakeup_line   = wake_reg;
  assign ext_irq_line  = wake_reg;
  assign scan_data_in  = scan_in_reg[0];
  assign scan_clk      = scan_in_reg[1];
  assign scan_mode_sel = scan_in_reg[2];
  assign converter0_standard_input_16 = conv_reg[0];
  assign converter0_standard_input_20 = conv_reg[1];
  assign converter0_standard_input_21 = conv_reg[2];

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  AST_PI5_SEL_ONE: assert property (
    (pad_config_reg[PAD_PI5] == {4'h0, SEL_ONE}) && alt_oe[1][PAD_PI5]
    |=> !pad_oe_n[PAD_PI5] && (pad_out[PAD_PI5] == $past(alt_out[1][PAD_PI5])))
    else $error("port I pin 5 not driven by timer channel");
  AST_PI6_SEL_TWO: assert property (
    (pad_config_reg[PAD_PI6] == {4'h0, SEL_TWO}) && alt_oe[2][PAD_PI6]
    |=> !pad_oe_n[PAD_PI6] && (pad_out[PAD_PI6] == $past(alt_out[2][PAD_PI6])))
    else $error("port I pin 6 not driven by serial select");
  AST_PI7_SEL_TWO: assert property (
    (pad_config_reg[PAD_PI7] == {4'h0, SEL_TWO}) ##1 $stable(pad_config_reg[PAD_PI7])
    |-> pad_oe_n[PAD_PI7] == !$past(alt_oe[2][PAD_PI7]))
    else $error("port I pin 7 enable not from serial select");
  AST_PI8_CONV: assert property (
    1'b1 |=> converter0_standard_input_16 == $past(pad_in[PAD_PI8]))
    else $error("converter channel 16 does not follow pad");
  AST_PI12_CONV: assert property (
    $rose(pad_in[PAD_PI12]) |=> converter0_standard_input_20)
    else $error("converter channel 20 missed a rise");
  AST_PI13_SEL_ONE_IN: assert property (
    (pad_config_reg[PAD_PI13][FSEL_LSB +: SEL_W] == SEL_ONE) && !pad_config_reg[PAD_PI13][NMI_BIT]
    |=> alt_in[1][PAD_PI13] == $past(pad_in[PAD_PI13]))
    else $error("serial select input of pin 13 wrong");
  AST_NMI_PRIORITY: assert property (
    pad_config_reg[PAD_PI5][NMI_BIT] |=> pad_oe_n[PAD_PI5] && !alt_in[1][PAD_PI5] && !alt_in[2][PAD_PI5])
    else $error("interrupt input did not override selector");
  AST_RESET_STATE: assert property (
    $fell(rst) |-> (pad_config_reg[PAD_PI5] == CFG_RST_TRI) && (pad_config_reg[PAD_PH9] == CFG_RST_SCAN)
                   && (pad_config_reg[PAD_PC1] == CFG_RST_TDO) && (pad_oe_n[5:0] == 6'h3f))
    else $error("reset configuration wrong");
  AST_SCAN_CLK: assert property (
    (pad_config_reg[PAD_PH9] == CFG_RST_SCAN) ##1 (pad_config_reg[PAD_PH9] == CFG_RST_SCAN)
    |=> scan_clk == $past(pad_in[PAD_PH9], 2))
    else $error("scan clock not taken from port H 9");
  AST_PC1_GPIO: assert property (
    (pad_config_reg[PAD_PC1][FSEL_LSB +: SEL_W] == SEL_GPIO) && pad_config_reg[PAD_PC1][OBE_BIT]
    && !pad_config_reg[PAD_PC1][NMI_BIT] |=> !pad_oe_n[PAD_PC1])
    else $error("port C 1 gpio output not enabled");
  AST_EMPTY_SEL: assert property (
    (pad_config_reg[PAD_PI8][FSEL_LSB +: SEL_W] != SEL_GPIO) |=> pad_oe_n[PAD_PI8])
    else $error("empty selector drove port I pin 8");
  AST_SCAN_DATA_IN: assert property (
    (pad_config_reg[PAD_PC0] == CFG_RST_SCAN) ##1 (pad_config_reg[PAD_PC0] == CFG_RST_SCAN)
    |=> scan_data_in == $past(pad_in[PAD_PC0], 2))
    else $error("scan data in not taken from port C 0");
  AST_SCAN_MODE: assert property (
    (pad_config_reg[PAD_PH10] == CFG_RST_SCAN) ##1 (pad_config_reg[PAD_PH10] == CFG_RST_SCAN)
    |=> scan_mode_sel == $past(pad_in[PAD_PH10], 2))
    else $error("scan mode select not taken from port H 10");
  AST_PC1_OBE_IDLE: assert property (
    (pad_config_reg[PAD_PC1] == CFG_RST_TDO) && !scan_data_out_en |=> pad_oe_n[PAD_PC1])
    else $error("port C 1 enable bit acted in selector two");
  AST_WAKE_IRQ: assert property (
    1'b1 |=> (ext_irq_line == wakeup_line) && (wakeup_line == ($past(pad_in) & WAKE_MASK)))
    else $error("wakeup line and external interrupt differ");
endmodule

/* File: pimux_far.sv */
// far-side pad model: pins echo what the mux drives, else an outside level
module pimux_far
  import pimux_pkg::*;
(
  input  wire logic [pimux_pkg::PAD_NUM-1:0] pad_out,
  input  wire logic [pimux_pkg::PAD_NUM-1:0] pad_oe_n,
  input  wire logic [pimux_pkg::PAD_NUM-1:0] ext_lvl,
  output logic      [pimux_pkg::PAD_NUM-1:0] pad_in
);
  assign pad_in = (pad_out & ~pad_oe_n) | (ext_lvl & pad_oe_n);
endmodule

/* File: tb_top.sv */
// self-checking bench for the port pad function multiplexer
module tb_top
  import pimux_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [3:1][PAD_NUM-1:0] FN_AV = {AVAIL_THREE, AVAIL_TWO, AVAIL_ONE};
  localparam logic [PAD_NUM-1:0]      WK    = 10'h155;
  logic                     core_clk, rst, scan_data_out, scan_data_out_en;
  logic                     scan_data_in, scan_clk, scan_mode_sel, cv16, cv20, cv21;
  logic [PAD_NUM-1:0]       cfg_wr_en, gpio_out, ext_lvl, pad_in, pad_out, pad_oe_n, pad_medium;
  logic [PAD_NUM-1:0]       gpio_in, nmi_in, e_out, e_oen, e_gin, e_nmi, pw_en;
  logic [CFG_W-1:0]         cfg_wr_data, pw_d;
  logic [CFG_W-1:0]         cfg_m [PAD_NUM];
  logic [3:1][PAD_NUM-1:0]  alt_out, alt_oe, alt_in_w, e_ain;
  logic [PAD_NUM-1:0]       wk_line, irq_line, e_wk;
  logic [PAD_NUM*CFG_W-1:0] pad_config_state;
  logic [2:0]               e_cv, d1, d2;
  logic [31:0]              seed;
  int                       n_fail, num_checks, cyc;

  pimux_top #(.WAKE_MASK(WK)) DUT (.core_clk(core_clk), .rst(rst), .cfg_wr_en(cfg_wr_en), .cfg_wr_data(cfg_wr_data),
    .gpio_out(gpio_out), .alt_out(alt_out), .alt_oe(alt_oe), .scan_data_out(scan_data_out),
    .scan_data_out_en(scan_data_out_en), .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
    .pad_medium(pad_medium), .pad_config_state(pad_config_state), .gpio_in(gpio_in), .alt_in(alt_in_w),
    .scan_data_in(scan_data_in), .scan_clk(scan_clk), .scan_mode_sel(scan_mode_sel), .nmi_in(nmi_in),
    .converter0_standard_input_16(cv16), .converter0_standard_input_20(cv20),
    .converter0_standard_input_21(cv21), .wakeup_line(wk_line), .ext_irq_line(irq_line));
  pimux_far far (.pad_out(pad_out), .pad_oe_n(pad_oe_n), .ext_lvl(ext_lvl), .pad_in(pad_in));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic sc(int i);
    return cfg_m[i][1:0] == SEL_TWO && !cfg_m[i][NMI_BIT];
  endfunction

  task automatic finish_test();
    if (n_fail == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [59:0] got, input logic [59:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic calc();
    logic [1:0]              s;
    logic                    live;
    logic [3:1][PAD_NUM-1:0] ao, ae;
    ao = alt_out;
    ae = alt_oe;
    ao[2][PAD_PC1] = scan_data_out;
    ae[2][PAD_PC1] = scan_data_out_en;
    for (int i = 0; i < PAD_NUM; i++)
    begin
      s = cfg_m[i][1:0];
      live = !cfg_m[i][NMI_BIT];
      if (s == SEL_GPIO)
      begin
        e_oen[i] = !(live && cfg_m[i][OBE_BIT]);
        e_out[i] = gpio_out[i];
      end
      else
      begin
        e_oen[i] = !(live && FN_AV[s][i] && ae[s][i]);
        e_out[i] = ao[s][i];
      end
      e_gin[i] = pad_in[i] & cfg_m[i][IBE_BIT];
      e_nmi[i] = pad_in[i] & cfg_m[i][NMI_BIT];
      for (int k = 1; k <= 3; k++)
        e_ain[k][i] = pad_in[i] & live & FN_AV[k][i] & (s == 2'(k));
    end
    e_wk = pad_in & WK;
    e_cv = {pad_in[PAD_PI13], pad_in[PAD_PI12], pad_in[PAD_PI8]};
    d2 = d1;
    d1 = {pad_in[PAD_PH10] & sc(PAD_PH10), pad_in[PAD_PH9] & sc(PAD_PH9), pad_in[PAD_PC0] & sc(PAD_PC0)};
  endtask

  task automatic step(input logic [PAD_NUM-1:0] wen, input logic [CFG_W-1:0] wd);
    @(negedge core_clk);
    chk(pad_oe_n, e_oen, "oe");
    chk(pad_out & ~e_oen, e_out & ~e_oen, "out");
    chk(gpio_in, e_gin, "gpio in");
    chk(nmi_in, e_nmi, "nmi in");
    chk(alt_in_w, e_ain, "alt in");
    chk({wk_line, irq_line}, {e_wk, e_wk}, "wake");
    chk({cv21, cv20, cv16}, e_cv, "conv");
    chk({scan_mode_sel, scan_clk, scan_data_in}, d2, "scan");
    for (int i = 0; i < PAD_NUM; i++)
    begin
      if (pw_en[i])
        cfg_m[i] = pw_d;
      chk(pad_config_state[i*CFG_W +: CFG_W], cfg_m[i], "cfg");
      chk(pad_medium[i], cfg_m[i][MED_BIT], "med");
    end
    pw_en = wen;
    pw_d = wd;
    cfg_wr_en = wen;
    cfg_wr_data = wd;
    {scan_data_out_en, scan_data_out, ext_lvl, gpio_out} = 22'(rnd());
    alt_out = 30'(rnd());
    // scan input lanes are input-only, never given a drive enable
    alt_oe = 30'(rnd()) & ~30'h000d0000;
    #1;
    calc();
  endtask

  task automatic do_reset();
    @(negedge core_clk);
    rst = 1'b1;
    cfg_wr_en = '0;
    pw_en = '0;
    repeat (3) @(negedge core_clk);
    chk(pad_config_state[35:0], 36'h0, "rst port i");
    chk({pad_medium[PAD_PC1], pad_config_state[44:42]}, 4'he, "rst pc1");
    chk({pad_config_state[55:54], pad_config_state[49:48], pad_config_state[37:36]}, 6'h2a, "rst scan");
    chk(pad_oe_n, 10'h3ff, "rst oe");
    rst = 1'b0;
    for (int i = 0; i < PAD_NUM; i++)
      cfg_m[i] = CFG_RST[i];
    d1 = 3'h0;
    calc();
  endtask

  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_fail++;
      finish_test();
    end
  end

  initial
  begin
    logic [31:0] w;
    {rst, cfg_wr_en, cfg_wr_data, gpio_out, alt_out, alt_oe, scan_data_out, scan_data_out_en, ext_lvl} = '1;
    {cfg_wr_en, cfg_wr_data, gpio_out, alt_out, alt_oe, scan_data_out, scan_data_out_en, ext_lvl} = '0;
    seed = 32'h28;
    for (int r = 0; r < 2; r++)
    begin
      do_reset();
      step(10'h000, 6'h00);
      step(10'h000, 6'h00);
      step(10'h080, 6'h04);
      step(10'h001, 6'h03);
      step(10'h002, 6'h12);
      step(10'h038, 6'h01);
      step(10'h007, 6'h02);
      step(10'h007, 6'h01);
      step(10'h340, 6'h0c);
      for (int k = 0; k < 200; k++)
      begin
        w = rnd();
        step(w[9:0] & w[19:10] & w[29:20], 6'(rnd()));
      end
    end
    step(10'h000, 6'h00);
    finish_test();
  end
endmodule
